// >>> hdl/burner_pkg.sv
package burner_pkg;

	// sequencer phases reported by the burner sequencer
	typedef enum logic [2:0] {
		PH_IDLE,
		PH_DRIVE_HIGH,
		PH_PURGE,
		PH_DRIVE_LOW,
		PH_PILOT_FLAME_ESTABLISH_PERIOD,
		PH_RUN
	} phase_t;

	// hold state of the test logic
	typedef enum logic {
		HS_FREE,
		HS_HELD
	} hold_t;

	// timing, in its own units
	localparam int CLK_PERIOD_NS   = 10;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
	localparam int PILOT_FLAME_ESTABLISH_PERIOD_LONG_HOLD_MS  = 8000;
	localparam int PILOT_FLAME_ESTABLISH_PERIOD_SHORT_HOLD_MS = 3000;
	localparam int FLAMEOUT_MS     = 15000;
	localparam int MS_W            = 16;

	// register map, byte addresses
	localparam int          ADDR_W      = 8;
	localparam logic [7:0]  ADDR_STATUS = 8'h00;
	localparam logic [7:0]  ADDR_MASK   = 8'h04;
	localparam logic [7:0]  ADDR_STATE  = 8'h08;
	localparam logic [7:0]  ADDR_KEY    = 8'h0c;
	localparam logic [7:0]  ADDR_ITEM   = 8'h10;

	// status and mask bit positions
	localparam int ST_W        = 4;
	localparam int ST_HOLD_ON  = 0;
	localparam int ST_HOLD_OFF = 1;
	localparam int ST_FLAMEOUT = 2;
	localparam int ST_ANN_CHG  = 3;

	// key bits
	localparam int KEY_NEXT = 0;
	localparam int KEY_PREV = 1;

	// annunciator items
	localparam int         N_TERMINALS  = 19;
	localparam int         ITEM_W       = 5;
	localparam logic [4:0] N_TERM_ITEMS = 5'h14;
	localparam logic [4:0] ITEM_FAULT   = 5'h14;
	localparam logic [4:0] ITEM_REV     = 5'h15;
	localparam logic [4:0] ITEM_LAST    = 5'h15;
	localparam logic [4:0] TERM_BASE    = 5'h04;
	// terminal number shown by each status item, in browsing order
	localparam logic [4:0] TERM_NUM [20] = '{
		5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d,
		5'h0e, 5'h0f, 5'h10, 5'h13, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16
	};

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : burner_pkg

// >>> hdl/burner_test_hold.sv
`timescale 1ns/1ps
// Summary of operation
// - annunciator absent: show a single fixed not-connected item instead of status items
// - annunciator present: one item per monitored terminal, two for T19, each a 1 or 0 value
// - valve closure on T4, burner switch on T5, operating control on T6
// - auxiliary limits T7, T8, T11; low water cutoff T9; high limit T10
// - oil select and oil pressure/temperature on T12 to T16; atomizing on T19
// - gas select T17, high gas T18, low gas T19, airflow T20, interlocks T21, T22
// - fault code item and software revision item follow the terminal items
// - annunciator items are browsed with the same next and previous keys
// - test in drive to high fire holds prepurge with motor at high fire
// - test in timed prepurge freezes the purge timer, motor stays at high fire
// - test in drive to low fire holds prepurge with motor at low fire
// - test stops pilot timer only in first 8 of 10 s or 3 of 4 s
// - while pilot period is held, a fifteen second flame-loss timer runs
// - test is ignored in pilot period when pilot and main outputs are strapped
// - test in run drives the firing-rate motor to low fire
// - after test is switched off, the sequence continues with no further hold
module burner_test_hold #(
	parameter int MS_CYCLES = burner_pkg::MS_CYCLES
) (
	// clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// axi4-lite write address
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// axi4-lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read address
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// axi4-lite read data
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// operator switch and sequencer
	input  wire logic                  test_switch,
	input  burner_pkg::phase_t         phase,
	input  wire logic                  pilot_flame_establish_period_long,
	input  wire logic                  pilot_main_strap_a,
	input  wire logic                  pilot_main_strap_b,
	input  wire logic                  flame_present,
	// sequencer and motor commands
	output logic                       sequence_hold,
	output logic                       purge_timer_run,
	output logic                       pilot_flame_establish_period_timer_run,
	output logic                       motor_force_high,
	output logic                       motor_force_low,
	output logic                       flameout_trip,
	// annunciator
	input  wire logic                  expansion_annunciator,
	input  wire logic [18:0]           terminal_state,
	input  wire logic [7:0]            ann_fault_code,
	input  wire logic [15:0]           ann_sw_revision,
	output logic [4:0]                 item_index,
	output logic [15:0]                item_value,
	output logic                       item_not_connected,
	// interrupt
	output logic                       irq
);

	typedef struct packed {
		logic                  awready;
		logic                  wready;
		logic                  aw_got;
		logic                  w_got;
		logic [7:0]            waddr;
		logic [31:0]           wdata;
		logic [3:0]            wstrb;
		logic                  bvalid;
		logic [1:0]            bresp;
		logic                  arready;
		logic                  rvalid;
		logic [31:0]           rdata;
		logic [1:0]            rresp;
		logic [3:0]            status;
		logic [3:0]            mask;
		logic                  irq;
		burner_pkg::hold_t     hold;
		logic                  motor_high;
		logic                  motor_low;
		logic                  purge_run;
		logic                  pilot_flame_establish_period_run;
		logic                  flameout;
		logic [4:0]            item_idx;
		logic [15:0]           item_value;
		logic                  item_nc;
		logic [18:0]           term_prev;
		logic                  ann_prev;
	} state_t;

	state_t q, d;

	logic [burner_pkg::MS_W-1:0] pilot_flame_establish_period_ms;
	logic [burner_pkg::MS_W-1:0] fo_ms;
	logic                        hold_point;
	logic                        held;
	logic                        pilot_flame_establish_period_count;
	logic                        fo_count;
	logic [burner_pkg::MS_W-1:0] pilot_flame_establish_period_limit;

	// elapsed pilot period time, frozen while held
	ms_timer #(.TICK_CYCLES(MS_CYCLES), .W(burner_pkg::MS_W)) u_pilot_flame_establish_period_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (pilot_flame_establish_period_count),
		.clear   (phase != burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD),
		.ms      (pilot_flame_establish_period_ms)
	);

	// flame-loss timer while the pilot period is held
	ms_timer #(.TICK_CYCLES(MS_CYCLES), .W(burner_pkg::MS_W)) u_flameout_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (fo_count),
		.clear   (!fo_count),
		.ms      (fo_ms)
	);

	// hold point of the current phase
	always_comb begin
		pilot_flame_establish_period_limit = pilot_flame_establish_period_long ? burner_pkg::MS_W'(burner_pkg::PILOT_FLAME_ESTABLISH_PERIOD_LONG_HOLD_MS)
			: burner_pkg::MS_W'(burner_pkg::PILOT_FLAME_ESTABLISH_PERIOD_SHORT_HOLD_MS);
		case (phase)
			burner_pkg::PH_DRIVE_HIGH: hold_point = 1'b1;
			burner_pkg::PH_PURGE:      hold_point = 1'b1;
			burner_pkg::PH_DRIVE_LOW:  hold_point = 1'b1;
			burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD:       hold_point = !(pilot_main_strap_a || pilot_main_strap_b)
				&& (pilot_flame_establish_period_ms < pilot_flame_establish_period_limit);
			default:                   hold_point = 1'b0;
		endcase
		held       = test_switch && hold_point;
		pilot_flame_establish_period_count = (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD) && !held;
		fo_count   = (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD) && held && !flame_present;
	end

	// next state of the whole block
	always_comb begin
		logic [3:0]  set;
		logic [3:0]  clr;
		logic [31:0] rd;
		logic [1:0]  rr;
		logic [4:0]  term_off;
		set      = 4'h0;
		clr      = 4'h0;
		rd       = 32'h0;
		rr       = burner_pkg::RESP_OKAY;
		term_off = 5'h0;
		d        = q;

		// hold tracking and motor commands
		if (held && q.hold == burner_pkg::HS_FREE) begin
			d.hold = burner_pkg::HS_HELD;
			set[burner_pkg::ST_HOLD_ON] = 1'b1;
		end else if (!held && q.hold == burner_pkg::HS_HELD) begin
			d.hold = burner_pkg::HS_FREE;
			set[burner_pkg::ST_HOLD_OFF] = 1'b1;
		end
		d.motor_high = test_switch && (phase == burner_pkg::PH_DRIVE_HIGH
			|| phase == burner_pkg::PH_PURGE);
		d.motor_low  = test_switch && (phase == burner_pkg::PH_DRIVE_LOW
			|| phase == burner_pkg::PH_RUN);
		d.purge_run  = (phase == burner_pkg::PH_PURGE) && !held;
		d.pilot_flame_establish_period_run   = pilot_flame_establish_period_count;
		// flameout trips at fifteen seconds without flame and holds for the period
		if (phase != burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD)
			d.flameout = 1'b0;
		else if (fo_ms >= burner_pkg::MS_W'(burner_pkg::FLAMEOUT_MS)) begin
			d.flameout = 1'b1;
			set[burner_pkg::ST_FLAMEOUT] = !q.flameout;
		end

		// annunciator change events
		d.term_prev = terminal_state;
		d.ann_prev  = expansion_annunciator;
		if (q.term_prev != terminal_state || q.ann_prev != expansion_annunciator)
			set[burner_pkg::ST_ANN_CHG] = 1'b1;

		// write channel: address and data in either order
		if (s_axi_awvalid && q.awready) begin
			d.aw_got = 1'b1;
			d.waddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		if (q.aw_got && q.w_got && !q.bvalid) begin
			d.aw_got = 1'b0;
			d.w_got  = 1'b0;
			d.bvalid = 1'b1;
			d.bresp  = burner_pkg::RESP_OKAY;
			if (q.waddr == burner_pkg::ADDR_MASK) begin
				if (q.wstrb[0])
					d.mask = q.wdata[3:0];
			end else if (q.waddr == burner_pkg::ADDR_KEY) begin
				// browsing keys, same as for ordinary second-line messages
				if (q.wstrb[0] && q.wdata[burner_pkg::KEY_NEXT] && expansion_annunciator)
					d.item_idx = (q.item_idx == burner_pkg::ITEM_LAST) ? 5'h0
						: q.item_idx + 5'h1;
				else if (q.wstrb[0] && q.wdata[burner_pkg::KEY_PREV] && expansion_annunciator)
					d.item_idx = (q.item_idx == 5'h0) ? burner_pkg::ITEM_LAST
						: q.item_idx - 5'h1;
			end else if (q.waddr == burner_pkg::ADDR_STATUS || q.waddr == burner_pkg::ADDR_STATE
				|| q.waddr == burner_pkg::ADDR_ITEM) begin
				d.bresp = burner_pkg::RESP_OKAY;                             // read-only, ignored
			end else begin
				d.bresp = burner_pkg::RESP_SLVERR;
			end
		end
		d.awready = !d.aw_got && !d.bvalid;
		d.wready  = !d.w_got && !d.bvalid;

		// read channel
		if (q.rvalid && s_axi_rready)
			d.rvalid = 1'b0;
		if (s_axi_arvalid && q.arready) begin
			if (s_axi_araddr == burner_pkg::ADDR_STATUS) begin
				rd  = {28'h0, q.status};
				clr = q.status;                                              // read clears
			end else if (s_axi_araddr == burner_pkg::ADDR_MASK) begin
				rd = {28'h0, q.mask};
			end else if (s_axi_araddr == burner_pkg::ADDR_STATE) begin
				rd = {21'h0, 3'(phase), 2'h0, q.flameout, expansion_annunciator,
					q.motor_low, q.motor_high, test_switch, q.hold == burner_pkg::HS_HELD};
			end else if (s_axi_araddr == burner_pkg::ADDR_KEY) begin
				rd = {27'h0, q.item_idx};
			end else if (s_axi_araddr == burner_pkg::ADDR_ITEM) begin
				rd = {q.item_value, 7'h0, q.item_nc, 3'h0, q.item_idx};
			end else begin
				rr = burner_pkg::RESP_SLVERR;
			end
			d.rvalid = 1'b1;
			d.rdata  = rd;
			d.rresp  = rr;
		end
		d.arready = !d.rvalid;

		// sticky status, a new event wins over the read clear
		d.status = (q.status & ~clr) | set;
		d.irq    = |(d.status & d.mask);

		// annunciator item shown on the display
		if (!expansion_annunciator) begin
			d.item_nc    = 1'b1;
			d.item_idx   = 5'h0;
			d.item_value = 16'h0;
		end else begin
			d.item_nc = 1'b0;
			if (q.item_idx < burner_pkg::N_TERM_ITEMS) begin
				term_off     = burner_pkg::TERM_NUM[q.item_idx] - burner_pkg::TERM_BASE;
				d.item_value = {15'h0, terminal_state[term_off]};
			end else if (q.item_idx == burner_pkg::ITEM_FAULT) begin
				d.item_value = {8'h0, ann_fault_code};
			end else begin
				d.item_value = ann_sw_revision;
			end
		end
	end

	// the single state register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	// outputs straight from flip-flops
	assign s_axi_awready      = q.awready;
	assign s_axi_wready       = q.wready;
	assign s_axi_bresp        = q.bresp;
	assign s_axi_bvalid       = q.bvalid;
	assign s_axi_arready      = q.arready;
	assign s_axi_rdata        = q.rdata;
	assign s_axi_rresp        = q.rresp;
	assign s_axi_rvalid       = q.rvalid;
	assign sequence_hold      = (q.hold == burner_pkg::HS_HELD);
	assign purge_timer_run    = q.purge_run;
	assign pilot_flame_establish_period_timer_run     = q.pilot_flame_establish_period_run;
	assign motor_force_high   = q.motor_high;
	assign motor_force_low    = q.motor_low;
	assign flameout_trip      = q.flameout;
	assign item_index         = q.item_idx;
	assign item_value         = q.item_value;
	assign item_not_connected = q.item_nc;
	assign irq                = q.irq;

	// checks
	localparam int FO_LIMIT = burner_pkg::FLAMEOUT_MS;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	high_hold_a: assert property (test_switch && phase == burner_pkg::PH_DRIVE_HIGH |=>
		sequence_hold && motor_force_high) else $error("no high fire hold");
	purge_freeze_a: assert property (test_switch && phase == burner_pkg::PH_PURGE |=>
		!purge_timer_run && motor_force_high) else $error("purge timer not frozen");
	low_hold_a: assert property (test_switch && phase == burner_pkg::PH_DRIVE_LOW |=>
		sequence_hold && motor_force_low) else $error("no low fire hold");
	pilot_flame_establish_period_limit_a: assert property (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD && pilot_flame_establish_period_ms >= pilot_flame_establish_period_limit
		|=> !sequence_hold) else $error("pilot held past its limit");
	flameout_time_a: assert property ($rose(flameout_trip) |->
		$past(fo_ms) >= FO_LIMIT && $past(phase) == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD) else $error("early flameout");
	strap_ignore_a: assert property (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD
		&& (pilot_main_strap_a || pilot_main_strap_b) |=> !sequence_hold) else $error("strap ignored");
	run_low_a: assert property (test_switch && phase == burner_pkg::PH_RUN |=>
		motor_force_low && !sequence_hold) else $error("run not at low fire");
	release_a: assert property (!test_switch |=> !sequence_hold
		&& !motor_force_high && !motor_force_low) else $error("hold not released");
	not_conn_a: assert property (!expansion_annunciator |=>
		item_not_connected && item_index == 5'h0) else $error("missing not connected item");
	purge_hold_c: cover property (test_switch && phase == burner_pkg::PH_PURGE ##1 sequence_hold);
	pilot_flame_establish_period_hold_c: cover property (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD && sequence_hold);
	flameout_c: cover property ($rose(flameout_trip));

endmodule : burner_test_hold

// >>> hdl/ms_timer.sv
`timescale 1ns/1ps
// millisecond counter that can be frozen and cleared; saturates at full scale
module ms_timer #(
	parameter int TICK_CYCLES = burner_pkg::MS_CYCLES,
	parameter int W           = burner_pkg::MS_W
) (
	// clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// control
	input  wire logic         run,
	input  wire logic         clear,
	// elapsed milliseconds
	output logic [W-1:0]      ms
);

	typedef struct packed {
		logic [31:0]  pre;
		logic [W-1:0] ms;
	} tstate_t;

	tstate_t q, d;

	// prescale to milliseconds while running, hold when frozen
	always_comb begin
		d = q;
		if (clear) begin
			d.pre = 32'h0;
			d.ms  = '0;
		end else if (run) begin
			if (q.pre == 32'(TICK_CYCLES - 1)) begin
				d.pre = 32'h0;
				if (q.ms != {W{1'b1}})
					d.ms = q.ms + 1'b1;
			end else begin
				d.pre = q.pre + 32'h1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			q <= '0;
		else
			q <= d;
	end

	assign ms = q.ms;

endmodule : ms_timer

// >>> tb/burner_far_side.sv
`timescale 1ns/1ps
// behavioural burner sequencer: timed phases advance only while the device lets them count
module burner_far_side (
	// clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	// heat demand and device commands
	input  wire logic          demand,
	input  wire logic          sequence_hold,
	input  wire logic          purge_timer_run,
	input  wire logic          pilot_flame_establish_period_timer_run,
	input  wire logic          flameout_trip,
	input  wire logic          pilot_flame_establish_period_long,
	// sequencer state
	output burner_pkg::phase_t phase
);
	int unsigned cnt_q;
	int unsigned len;
	logic        step;

	// length of each phase and whether it may count this cycle
	always_comb begin
		len = (phase == burner_pkg::PH_PURGE) ? 30 : (phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD) ? (pilot_flame_establish_period_long ? 10000 : 4000) : 20;
		step = (phase == burner_pkg::PH_PURGE) ? purge_timer_run :
			(phase == burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD) ? pilot_flame_establish_period_timer_run : !sequence_hold;
	end

	// phase walk; a flame-loss trip shuts the burner down
	always @(posedge aclk) begin
		if (!aresetn || flameout_trip) begin
			phase <= burner_pkg::PH_IDLE;
			cnt_q <= 0;
		end else if (phase == burner_pkg::PH_IDLE) begin
			if (demand) phase <= burner_pkg::PH_DRIVE_HIGH;
		end else if (phase == burner_pkg::PH_RUN) begin
			if (!demand) phase <= burner_pkg::PH_IDLE;
		end else if (cnt_q >= len) begin
			phase <= burner_pkg::phase_t'(phase + 3'h1);
			cnt_q <= 0;
		end else if (step) begin
			cnt_q <= cnt_q + 1;
		end
	end
endmodule : burner_far_side

// >>> tb/tb_burner_test_hold.sv
`timescale 1ns/1ps
module tb_burner_test_hold;
	localparam int term_of [20] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 19, 17, 18, 19, 20, 21, 22};
	logic               aclk = 1'b0, aresetn = 1'b0, demand = 1'b0;
	logic [7:0]         s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]         s_axi_wstrb = 4'hf;
	logic               s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic               s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]         s_axi_bresp, s_axi_rresp;
	logic               test_switch = 1'b0, pilot_flame_establish_period_long = 1'b0, flame_present = 1'b0;
	logic               pilot_main_strap_a = 1'b0, pilot_main_strap_b = 1'b0, expansion_annunciator = 1'b0;
	logic [18:0]        terminal_state = 19'h0;
	logic [7:0]         ann_fault_code = 8'h5a;
	logic [15:0]        ann_sw_revision = 16'h1234;
	burner_pkg::phase_t phase;
	logic               sequence_hold, purge_timer_run, pilot_flame_establish_period_timer_run, motor_force_high, motor_force_low;
	logic               flameout_trip, item_not_connected, irq;
	logic [4:0]         item_index;
	logic [15:0]        item_value;
	int                 num_errors = 0, num_checks = 0, cycles = 0;

	burner_test_hold #(.MS_CYCLES(1)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.test_switch, .phase, .pilot_flame_establish_period_long, .pilot_main_strap_a, .pilot_main_strap_b, .flame_present,
		.sequence_hold, .purge_timer_run, .pilot_flame_establish_period_timer_run, .motor_force_high, .motor_force_low, .flameout_trip,
		.expansion_annunciator, .terminal_state, .ann_fault_code, .ann_sw_revision, .item_index, .item_value,
		.item_not_connected, .irq);

	burner_far_side far (.aclk, .aresetn, .demand, .sequence_hold, .purge_timer_run, .pilot_flame_establish_period_timer_run,
		.flameout_trip, .pilot_flame_establish_period_long, .phase);

	// clock and hang guard
	always #5 aclk = ~aclk;
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check(s_axi_bresp, er);
	endtask : wr

	// one read: returns data and response
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd

	task automatic wait_phase(input burner_pkg::phase_t p);
		while (phase !== p) @(posedge aclk);
	endtask : wait_phase

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [31:0] e;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
		// register basics and refusals
		rd(burner_pkg::ADDR_MASK, d, r);
		check(d, 32'h0);
		rd(8'h20, d, r);
		check(d, 32'h0);
		check(32'(r), 32'(burner_pkg::RESP_SLVERR));
		wr(8'h20, 32'h1, burner_pkg::RESP_SLVERR);
		wr(burner_pkg::ADDR_STATE, 32'h1, burner_pkg::RESP_OKAY);
		// annunciator absent: fixed indication, keys do nothing
		check(item_not_connected, 1'b1);
		wr(burner_pkg::ADDR_KEY, 32'h1, burner_pkg::RESP_OKAY);
		rd(burner_pkg::ADDR_ITEM, d, r);
		check({d[8], d[4:0], item_index}, {1'b1, 5'h00, 5'h00});
		// annunciator present: browse all items twice with inverted inputs
		expansion_annunciator <= 1'b1;
		for (int p = 0; p < 2; p++) begin
			terminal_state <= p ? 19'h25a5c : 19'h5a5a3;
			for (int i = 0; i < 22; i++) begin
				repeat (2) @(posedge aclk);
				if (i < 20) e = 32'(terminal_state[term_of[i] - 4]);
				else e = (i == 20) ? 32'(ann_fault_code) : 32'(ann_sw_revision);
				check({item_not_connected, item_index}, {1'b0, 5'(i)});
				check(item_value, e);
				wr(burner_pkg::ADDR_KEY, 32'h1, burner_pkg::RESP_OKAY);
			end
			repeat (2) @(posedge aclk);
			check(item_index, 5'h00);
		end
		wr(burner_pkg::ADDR_KEY, 32'h2, burner_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(item_index, burner_pkg::ITEM_LAST);
		rd(burner_pkg::ADDR_KEY, d, r);
		check(d, 32'(burner_pkg::ITEM_LAST));
		rd(burner_pkg::ADDR_STATUS, d, r);
		// hold in drive to high fire, interrupt masked then unmasked
		demand <= 1'b1;
		wait_phase(burner_pkg::PH_DRIVE_HIGH);
		test_switch <= 1'b1;
		repeat (40) @(posedge aclk);
		check(phase, burner_pkg::PH_DRIVE_HIGH);
		check({sequence_hold, motor_force_high, motor_force_low, irq}, 4'b1100);
		wr(burner_pkg::ADDR_MASK, 32'hf, burner_pkg::RESP_OKAY);
		repeat (2) @(posedge aclk);
		check(irq, 1'b1);
		rd(burner_pkg::ADDR_STATUS, d, r);
		check(d[0], 1'b1);
		repeat (2) @(posedge aclk);
		check(irq, 1'b0);
		test_switch <= 1'b0;
		wait_phase(burner_pkg::PH_PURGE);
		// timed purge frozen
		repeat (10) @(posedge aclk);
		test_switch <= 1'b1;
		repeat (50) @(posedge aclk);
		check({phase, purge_timer_run, motor_force_high}, {burner_pkg::PH_PURGE, 2'b01});
		test_switch <= 1'b0;
		repeat (3) @(posedge aclk);
		check(purge_timer_run, 1'b1);
		// drive to low fire held
		wait_phase(burner_pkg::PH_DRIVE_LOW);
		test_switch <= 1'b1;
		repeat (40) @(posedge aclk);
		check({phase, sequence_hold, motor_force_high, motor_force_low}, {burner_pkg::PH_DRIVE_LOW, 3'b101});
		test_switch <= 1'b0;
		// pilot period held without flame until the flame-loss trip
		wait_phase(burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD);
		test_switch <= 1'b1;
		repeat (3) @(posedge aclk);
		check({sequence_hold, pilot_flame_establish_period_timer_run}, 2'b10);
		repeat (14900) @(posedge aclk);
		check(flameout_trip, 1'b0);
		for (int n = 0; n < 300 && !flameout_trip; n++) @(posedge aclk);
		check(flameout_trip, 1'b1);
		test_switch <= 1'b0;
		demand <= 1'b0;
		rd(burner_pkg::ADDR_STATUS, d, r);
		check(d[2], 1'b1);
		// strapped outputs ignore test; late test is not honoured; run drives low fire
		pilot_main_strap_b <= 1'b1;
		flame_present <= 1'b1;
		demand <= 1'b1;
		wait_phase(burner_pkg::PH_PILOT_FLAME_ESTABLISH_PERIOD);
		test_switch <= 1'b1;
		repeat (3) @(posedge aclk);
		check({sequence_hold, pilot_flame_establish_period_timer_run}, 2'b01);
		pilot_main_strap_b <= 1'b0;
		pilot_main_strap_a <= 1'b1;
		repeat (3) @(posedge aclk);
		check({sequence_hold, pilot_flame_establish_period_timer_run}, 2'b01);
		pilot_main_strap_a <= 1'b0;
		repeat (3) @(posedge aclk);
		check({sequence_hold, pilot_flame_establish_period_timer_run}, 2'b10);
		test_switch <= 1'b0;
		repeat (3) @(posedge aclk);
		check(pilot_flame_establish_period_timer_run, 1'b1);
		repeat (3100) @(posedge aclk);
		test_switch <= 1'b1;
		repeat (3) @(posedge aclk);
		check({sequence_hold, pilot_flame_establish_period_timer_run}, 2'b01);
		wait_phase(burner_pkg::PH_RUN);
		repeat (3) @(posedge aclk);
		check({sequence_hold, motor_force_high, motor_force_low}, 3'b001);
		rd(burner_pkg::ADDR_STATE, d, r);
		check(d, {21'h0, 3'(burner_pkg::PH_RUN), 8'h1a});
		test_switch <= 1'b0;
		repeat (3) @(posedge aclk);
		check(motor_force_low, 1'b0);
		demand <= 1'b0;
		give_verdict();
	end
endmodule : tb_burner_test_hold
